// ---- hw/repeater_port_rx_error_stats.sv ----
`default_nettype none

module repeater_port_rx_error_stats
  import rx_stats_pkg::*;
#(
  // Frame length limits in bytes, both ends inclusive
  parameter int unsigned MIN_LEN = MIN_LEN_LIMIT,
  parameter int unsigned MAX_LEN = MAX_LEN_LIMIT,
  // Burst ceiling and packet floor in bit times
  parameter int unsigned SHORT_CEIL = SHORT_BURST_CEILING_BT,
  parameter int unsigned PACKET_FLOOR = LEGAL_PACKET_FLOOR_BT,
  // Runt test select: 0 for the timing test, 1 for the tally test
  parameter bit USE_TALLY_RUNT = 1'b0,
  // Counter widths; the byte counter takes whole tallies
  parameter int unsigned CNT_W = EVENT_CNT_W,
  parameter int unsigned BYTES_W = BYTE_CNT_W
) (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Receive path indications, all on the port clock
  input wire logic carrier_activity,
  input wire logic bit_tick,
  input wire logic byte_valid,
  input wire logic crc_fail_flag,
  input wire logic odd_bit_flag,
  input wire logic collide_flag,
  // Counters read by the management side
  output logic [CNT_W-1:0] good_frame_count,
  output logic [BYTES_W-1:0] good_byte_count,
  output logic [CNT_W-1:0] crc_error_count,
  output logic [CNT_W-1:0] align_error_count,
  output logic [CNT_W-1:0] over_length_count,
  output logic [CNT_W-1:0] short_burst_count,
  output logic [CNT_W-1:0] runt_count
);

  // Refuse settings the classifier cannot serve; these checks act at
  // elaboration, so a bad parameter set never reaches simulation
  if (SHORT_CEIL <= SHORT_CEIL_LOW_BT || SHORT_CEIL >= SHORT_CEIL_HIGH_BT) begin : g_bad_ceiling
    // The ceiling must keep margin on both sides for circuit losses
    $error("short burst ceiling out of range");
  end
  if (PACKET_FLOOR < FLOOR_LOW_BT || PACKET_FLOOR >= FLOOR_HIGH_BT) begin : g_bad_floor
    // A floor outside its band would misfile legal packets as runts
    $error("legal packet floor out of range");
  end
  if (PACKET_FLOOR <= SHORT_CEIL) begin : g_bad_order
    // The runt band between ceiling and floor must not be empty
    $error("packet floor not above burst ceiling");
  end
  if (MIN_LEN > MAX_LEN || MAX_LEN >= (1 << LEN_W) - 1) begin : g_bad_limits
    // The tally saturates at its top value, so the maximum must sit below it
    $error("frame length limits unusable");
  end
  if (CNT_W < 1 || BYTES_W < LEN_W) begin : g_bad_widths
    // The byte counter must take a whole tally in one step
    $error("counter widths too small");
  end

  // Per-activity measurement state; all measures live in one register so
  // a low enable holds them together with the counters
  typedef struct packed {
    logic carrier_prev; // Carrier seen in the last enabled cycle
    logic [LEN_W-1:0] activity_length; // Bit times of the current activity
    logic [LEN_W-1:0] byte_tally; // Whole bytes after the frame start
    logic crc_seen; // Checksum failure seen during activity
    logic odd_seen; // Odd bit framing seen during activity
    logic collide_seen; // Collision seen during activity
  } meas_state_t;

  meas_state_t state_q;
  meas_state_t state_d;

  // Counter bank increment strobes and amounts
  logic [NUM_EVENT_CNT-1:0] event_inc;
  logic good_byte_inc;
  logic activity_end;
  logic tally_in_range;
  logic tally_over;

  // Outcome of each class test on the finished activity
  logic frame_good; // In range, clean checksum, no collision
  logic frame_crc; // In range, checksum failure, whole framing
  logic frame_align; // In range, checksum failure with odd bits
  logic burst_short; // Shorter than the burst ceiling
  logic runt_by_time; // Shorter than the packet floor
  logic runt_by_tally; // Fewer bytes than the runt limit
  logic runt_hit; // Runt under the selected test

  // Saturating increment keeps a stuck carrier from wrapping the measure;
  // a saturated tally still reads as over length at the end
  function automatic logic [LEN_W-1:0] sat_inc(input logic [LEN_W-1:0] val);
    logic [LEN_W-1:0] res;
    res = val;
    if (val != {LEN_W{1'b1}}) begin
      res = LEN_W'(val + LEN_W'(1));
    end
    return res;
  endfunction : sat_inc

  // Inclusive length window test, used for good and error frames;
  // widened to 32 bits so the compare against the limits loses nothing
  function automatic logic len_in_range(input logic [LEN_W-1:0] tally);
    return (32'(tally) >= MIN_LEN) && (32'(tally) <= MAX_LEN);
  endfunction : len_in_range

  // Timing: the first enabled cycle with carrier low after carrier high
  // is the end cycle; the classifier strobes then and the counters show
  // the result one edge later. One low cycle between activities is
  // enough, as the next rising carrier restarts every measure.
  // Measurement: count bit times and bytes, latch flags during activity
  always_comb begin
    state_d = state_q;
    state_d.carrier_prev = carrier_activity;
    if (carrier_activity) begin
      // A fresh activity restarts every measure
      if (!state_q.carrier_prev) begin
        state_d.activity_length = '0;
        state_d.byte_tally = '0;
        state_d.crc_seen = 1'b0;
        state_d.odd_seen = 1'b0;
        state_d.collide_seen = 1'b0;
      end
      // Bit time ticks give the activity length
      if (bit_tick) begin
        state_d.activity_length = sat_inc(state_d.activity_length);
      end
      // Only whole bytes after the frame start strobe, so checksum bytes
      // count while preamble and trailing dribble bits never do
      if (byte_valid) begin
        state_d.byte_tally = sat_inc(state_d.byte_tally);
      end
      // Flags are sticky over the whole activity
      if (crc_fail_flag) begin
        state_d.crc_seen = 1'b1;
      end
      if (odd_bit_flag) begin
        state_d.odd_seen = 1'b1;
      end
      if (collide_flag) begin
        state_d.collide_seen = 1'b1;
      end
    end
  end

  // Measurement register; reset acts whatever the enable, and a low
  // enable freezes every measure along with the counters
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      // Reset clears every measure
      state_q <= '0;
    end else if (clk_en) begin
      // Take the next measure only on enabled edges
      state_q <= state_d;
    end
  end

  // End of activity is the first cycle with carrier gone
  assign activity_end = state_q.carrier_prev && !carrier_activity;

  // Length window tests on the finished tally
  assign tally_in_range = len_in_range(state_q.byte_tally);
  assign tally_over = 32'(state_q.byte_tally) > MAX_LEN;

  // Class tests on the finished activity, kept apart from the strobes
  assign frame_good = tally_in_range && !state_q.crc_seen && !state_q.collide_seen;
  assign frame_crc = tally_in_range && state_q.crc_seen && !state_q.odd_seen && !state_q.collide_seen;
  assign frame_align = tally_in_range && state_q.crc_seen && state_q.odd_seen && !state_q.collide_seen;
  assign burst_short = 32'(state_q.activity_length) < SHORT_CEIL;
  // Length equal to the ceiling falls to the runt side, so a collision-free event
  // between the two ceiling bounds counts as short or, when the runt test is met, as runt
  assign runt_by_time = 32'(state_q.activity_length) < PACKET_FLOOR;
  assign runt_by_tally = 32'(state_q.byte_tally) < RUNT_BYTE_LIMIT;
  // Only one runt test is built in; the parameter picks which
  assign runt_hit = USE_TALLY_RUNT ? runt_by_tally : runt_by_time;

  // Class table applied at the end of each activity:
  //   good   in range, no checksum failure, no collision
  //   crc    in range, checksum failure, whole framing, no collision
  //   align  in range, checksum failure, odd bits, no collision
  //   over   tally above the maximum, whatever the flags
  //   short  length below the ceiling, whatever the flags
  //   runt   length from the ceiling up, no collision, runt test met
  // An activity lands in at most one of good, crc, align and over, and
  // in at most one of short and runt; a collided activity reaches only
  // the over and short counters.
  // Classifier: sorts each finished activity into the counters
  always_comb begin
    event_inc = '0;
    good_byte_inc = 1'b0;
    if (activity_end) begin
      // Good frame: count it and add its bytes
      if (frame_good) begin
        event_inc[IDX_GOOD] = 1'b1;
        good_byte_inc = 1'b1;
      end
      // Checksum error only when framing was whole
      if (frame_crc) begin
        event_inc[IDX_CRC] = 1'b1;
      end
      // Alignment error takes the frame away from the checksum counter
      if (frame_align) begin
        event_inc[IDX_ALIGN] = 1'b1;
      end
      // Over length; the range tests above already exclude it
      if (tally_over) begin
        event_inc[IDX_LONG] = 1'b1;
      end
      // Short burst below the ceiling, whatever the flags
      if (burst_short) begin
        event_inc[IDX_SHORT] = 1'b1;
      end else if (!state_q.collide_seen && runt_hit) begin
        // From the ceiling up, a collision-free activity may be a runt
        event_inc[IDX_RUNT] = 1'b1;
      end
    end
  end

  // Event counters, each adds one per strobe and wraps; they share the
  // enable with the measures so a frozen block counts nothing
  logic [CNT_W-1:0] event_count [NUM_EVENT_CNT];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENT_CNT; gi++) begin : g_evt
      stat_counter #(
        .WIDTH(CNT_W),
        .INC_W(1)
      ) u_evt (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .inc_en(event_inc[gi]),
        .inc_amount(1'b1),
        .count(event_count[gi])
      );
    end
  endgenerate

  // Byte counter adds the whole tally of each good frame in one step;
  // the tally is zero-extended to the counter width inside the counter
  stat_counter #(
    .WIDTH(BYTES_W),
    .INC_W(LEN_W)
  ) u_bytes (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .inc_en(good_byte_inc),
    .inc_amount(state_q.byte_tally),
    .count(good_byte_count)
  );

  // Read-only counter outputs, straight from counter flip-flops; the
  // management side has no path to load or clear them
  assign good_frame_count = event_count[IDX_GOOD];
  assign crc_error_count = event_count[IDX_CRC];
  assign align_error_count = event_count[IDX_ALIGN];
  assign over_length_count = event_count[IDX_LONG];
  assign short_burst_count = event_count[IDX_SHORT];
  assign runt_count = event_count[IDX_RUNT];

endmodule : repeater_port_rx_error_stats

`default_nettype wire

// ---- hw/stat_counter.sv ----
`default_nettype none

module stat_counter #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned INC_W = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic inc_en,
  input wire logic [INC_W-1:0] inc_amount,
  output logic [WIDTH-1:0] count
);

  // Whole state of the counter
  typedef struct packed {
    logic [WIDTH-1:0] value;
  } cnt_state_t;

  cnt_state_t state_q;
  cnt_state_t state_d;

  // Refuse an increment that the counter could not take in one step
  if (INC_W > WIDTH) begin : g_bad_width
    $error("stat_counter: increment wider than counter");
  end

  // Add the increment; the sum is cut to WIDTH so it wraps past the top
  always_comb begin
    state_d = state_q;
    if (inc_en) begin
      state_d.value = WIDTH'(state_q.value + WIDTH'(inc_amount));
    end
  end

  // Register with synchronous reset and clock enable
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  assign count = state_q.value;

endmodule : stat_counter

`default_nettype wire

// ---- pkg/rx_stats_pkg.sv ----
`default_nettype none

package rx_stats_pkg;

  // Frame length limits in bytes, inclusive at both ends
  localparam int unsigned MIN_LEN_LIMIT = 64;
  localparam int unsigned MAX_LEN_LIMIT = 1518;

  // Runt test on byte tally: frames shorter than this are runts
  localparam int unsigned RUNT_BYTE_LIMIT = 64;

  // Short burst ceiling in bit times, must sit strictly inside 74..82
  localparam int unsigned SHORT_BURST_CEILING_BT = 78;
  localparam int unsigned SHORT_CEIL_LOW_BT = 74;
  localparam int unsigned SHORT_CEIL_HIGH_BT = 82;

  // Legal packet floor in bit times, allowed 552 up to but not 565
  localparam int unsigned LEGAL_PACKET_FLOOR_BT = 556;
  localparam int unsigned FLOOR_LOW_BT = 552;
  localparam int unsigned FLOOR_HIGH_BT = 565;

  // Counter and measurement widths
  localparam int unsigned EVENT_CNT_W = 32;
  localparam int unsigned BYTE_CNT_W = 64;
  localparam int unsigned LEN_W = 16;

  // Index of each event counter in the counter bank
  localparam int unsigned IDX_GOOD = 0;
  localparam int unsigned IDX_CRC = 1;
  localparam int unsigned IDX_ALIGN = 2;
  localparam int unsigned IDX_LONG = 3;
  localparam int unsigned IDX_SHORT = 4;
  localparam int unsigned IDX_RUNT = 5;
  localparam int unsigned NUM_EVENT_CNT = 6;

endpackage : rx_stats_pkg

`default_nettype wire

// ---- testbench/repeater_port_rx_error_stats_checker.sv ----
`default_nettype none
// Watches the counter bank at the block's ports
module repeater_port_rx_error_stats_checker #(
  parameter int unsigned MIN_LEN = 64,
  parameter int unsigned MAX_LEN = 1518,
  parameter int unsigned CNT_W = 32,
  parameter int unsigned BYTES_W = 64
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic carrier_activity,
  input wire logic bit_tick,
  input wire logic byte_valid,
  input wire logic crc_fail_flag,
  input wire logic odd_bit_flag,
  input wire logic collide_flag,
  input wire logic [CNT_W-1:0] good_frame_count,
  input wire logic [BYTES_W-1:0] good_byte_count,
  input wire logic [CNT_W-1:0] crc_error_count,
  input wire logic [CNT_W-1:0] align_error_count,
  input wire logic [CNT_W-1:0] over_length_count,
  input wire logic [CNT_W-1:0] short_burst_count,
  input wire logic [CNT_W-1:0] runt_count
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Activity ended one edge ago: carrier high two edges ago, low one edge ago
  sequence s_ended;
    $past(carrier_activity, 2) && !$past(carrier_activity);
  endsequence
  // Carrier and collision as the block saw them on enabled edges
  logic carrier_q;
  logic coll_q;
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      carrier_q <= carrier_activity;
      if (carrier_activity) begin
        coll_q <= (coll_q && carrier_q) || collide_flag;
      end
    end
  end
  // End cycle of an activity that saw a collision
  sequence s_collided_end;
    clk_en && carrier_q && !carrier_activity && coll_q;
  endsequence
  a_collide_quiet: assert property (s_collided_end |=> $stable(good_frame_count) && $stable(runt_count) &&
    $stable(crc_error_count) && $stable(align_error_count))
    else $error("collided activity counted as frame or runt");
  a_freeze_hold: assert property (!$past(clk_en) && $past(nrst) |-> $stable(good_frame_count) &&
    $stable(good_byte_count) && $stable(short_burst_count) && $stable(runt_count))
    else $error("counter moved while enable low");
  a_reset_zero: assert property ($rose(nrst) |-> good_frame_count == '0 && runt_count == '0 &&
    good_byte_count == '0 && crc_error_count == '0 && align_error_count == '0 &&
    over_length_count == '0 && short_burst_count == '0)
    else $error("counters not clear after reset");
  a_crc_step: assert property ($changed(crc_error_count) |-> crc_error_count == $past(crc_error_count) + 1'b1)
    else $error("crc count stepped wrongly");
  a_crc_align_excl: assert property (!($changed(crc_error_count) && $changed(align_error_count)))
    else $error("crc and align counted together");
  a_long_excl: assert property ($changed(over_length_count) |-> $stable(crc_error_count) && $stable(align_error_count))
    else $error("over-length frame also counted as error");
  a_short_runt: assert property (!($changed(short_burst_count) && $changed(runt_count)))
    else $error("short and runt counted together");
  a_good_pair: assert property ($changed(good_frame_count) == $changed(good_byte_count))
    else $error("frame and byte counts out of step");
  a_good_bytes: assert property ($changed(good_frame_count) |-> (good_byte_count - $past(good_byte_count)) inside {[MIN_LEN:MAX_LEN]})
    else $error("good frame tally out of range");
  a_end_timing: assert property ($changed(runt_count) || $changed(short_burst_count) |-> s_ended)
    else $error("event counted away from activity end");
endmodule : repeater_port_rx_error_stats_checker

bind repeater_port_rx_error_stats repeater_port_rx_error_stats_checker #(
  .MIN_LEN(MIN_LEN), .MAX_LEN(MAX_LEN), .CNT_W(CNT_W), .BYTES_W(BYTES_W)
) checker_i (.sys_clk, .nrst, .clk_en, .carrier_activity, .bit_tick, .byte_valid,
  .crc_fail_flag, .odd_bit_flag, .collide_flag, .good_frame_count, .good_byte_count,
  .crc_error_count, .align_error_count, .over_length_count, .short_burst_count, .runt_count);
`default_nettype wire

// ---- testbench/repeater_port_rx_error_stats_tb_top.sv ----
`default_nettype none
module repeater_port_rx_error_stats_tb_top import rx_stats_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // Row: bit ticks, bytes, {crc, odd, collide}, counters hit; bit 6 is
  // the runt count of the instance built with the tally runt test
  typedef struct packed {
    logic [15:0] l;
    logic [15:0] t;
    logic [2:0] f;
    logic [6:0] m;
  } row_t;
  localparam row_t ROWS [12] = '{
    '{16'h0258, 16'h0040, 3'h0, 7'h01}, '{16'h05EE, 16'h05EE, 3'h0, 7'h01},
    '{16'h0258, 16'h0064, 3'h4, 7'h02}, '{16'h0258, 16'h0064, 3'h6, 7'h04},
    '{16'h0640, 16'h05EF, 3'h6, 7'h08}, '{16'h0258, 16'h0064, 3'h1, 7'h00},
    '{16'h004D, 16'h0009, 3'h0, 7'h10}, '{16'h004E, 16'h0009, 3'h0, 7'h60},
    '{16'h022B, 16'h003C, 3'h0, 7'h60}, '{16'h022C, 16'h003C, 3'h0, 7'h40},
    '{16'h000A, 16'h0001, 3'h1, 7'h10}, '{16'h0258, 16'h003F, 3'h0, 7'h40}};
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic start = 1'b0;
  logic [15:0] len = 16'h0000;
  logic [15:0] tally = 16'h0000;
  logic [2:0] flags = 3'h0;
  logic carrier_activity, bit_tick, byte_valid, crc_fail_flag, odd_bit_flag, collide_flag;
  logic [EVENT_CNT_W-1:0] good_frame_count, crc_error_count, align_error_count;
  logic [EVENT_CNT_W-1:0] over_length_count, short_burst_count, runt_count;
  logic [BYTE_CNT_W-1:0] good_byte_count;
  logic [EVENT_CNT_W-1:0] tally_runt_count; // Runt count of the tally-test instance
  logic [63:0] exp_cnt [7]; // Expected event counts
  logic [63:0] exp_bytes; // Expected good byte sum
  int mismatches = 0;
  int n_checks = 0;
  repeater_port_rx_error_stats repeater_port_rx_error_stats_i (.sys_clk, .nrst, .clk_en,
    .carrier_activity, .bit_tick, .byte_valid, .crc_fail_flag, .odd_bit_flag, .collide_flag,
    .good_frame_count, .good_byte_count, .crc_error_count, .align_error_count,
    .over_length_count, .short_burst_count, .runt_count);
  // Second instance built with the tally runt test
  repeater_port_rx_error_stats #(
    .USE_TALLY_RUNT(1'b1)
  ) repeater_port_rx_error_stats_tally_i (.sys_clk, .nrst, .clk_en,
    .carrier_activity, .bit_tick, .byte_valid, .crc_fail_flag, .odd_bit_flag, .collide_flag,
    .good_frame_count(), .good_byte_count(), .crc_error_count(), .align_error_count(),
    .over_length_count(), .short_burst_count(), .runt_count(tally_runt_count));
  rx_port_model rx_port_model_i (.sys_clk, .start, .len, .tally, .flags, .carrier_activity,
    .bit_tick, .byte_valid, .crc_fail_flag, .odd_bit_flag, .collide_flag);
  task automatic test_done;
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  task automatic check(input string nm, input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
    end
  endtask : check
  // Compare the whole bank with the running totals
  task automatic check_all;
    check("good_frames", good_frame_count, exp_cnt[0]);
    check("good_bytes", good_byte_count, exp_bytes);
    check("crc_errors", crc_error_count, exp_cnt[1]);
    check("align_errors", align_error_count, exp_cnt[2]);
    check("over_length", over_length_count, exp_cnt[3]);
    check("short_bursts", short_burst_count, exp_cnt[4]);
    check("runts", runt_count, exp_cnt[5]);
    check("tally_runts", tally_runt_count, exp_cnt[6]);
  endtask : check_all
  // Play one activity, wait for its end, then book the expected hits
  task automatic send(input row_t r);
    int k;
    @(posedge sys_clk);
    len <= r.l;
    tally <= r.t;
    flags <= r.f;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    #1;
    k = 0;
    while (carrier_activity === 1'b1 && k < 4000) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    repeat (3) @(posedge sys_clk);
    #1;
    for (int i = 0; i < 7; i++) if (r.m[i] && clk_en) exp_cnt[i] = exp_cnt[i] + 64'h1;
    if (r.m[0] && clk_en) exp_bytes = exp_bytes + r.t;
  endtask : send
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // Watchdog sized well beyond the longest run
  initial begin
    #1000000;
    mismatches++;
    test_done();
  end
  initial begin
    foreach (exp_cnt[i]) exp_cnt[i] = '0;
    exp_bytes = '0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    check_all();
    foreach (ROWS[i]) begin
      send(ROWS[i]);
      check_all();
    end
    // Disabled clock freezes the counters
    @(posedge sys_clk);
    clk_en <= 1'b0;
    send(ROWS[6]);
    check_all();
    @(posedge sys_clk);
    clk_en <= 1'b1;
    // Second reset clears, counting resumes
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (exp_cnt[i]) exp_cnt[i] = '0;
    exp_bytes = '0;
    #1;
    check_all();
    send(ROWS[7]);
    check_all();
    test_done();
  end
endmodule : repeater_port_rx_error_stats_tb_top
`default_nettype wire

// ---- testbench/rx_port_model.sv ----
`default_nettype none
// Port receive path: plays one carrier activity per start pulse
module rx_port_model (
  input wire logic sys_clk,
  input wire logic start,
  input wire logic [15:0] len,
  input wire logic [15:0] tally,
  input wire logic [2:0] flags,
  output logic carrier_activity,
  output logic bit_tick,
  output logic byte_valid,
  output logic crc_fail_flag,
  output logic odd_bit_flag,
  output logic collide_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] n = 16'h0000; // Cycles into the activity
  logic [15:0] dur = 16'h0000; // Activity span in cycles
  // Restart on start, then step until the span is used up
  always @(posedge sys_clk) begin
    if (start) begin
      n <= 16'h0000;
      dur <= (len > tally) ? len : tally;
    end else if (n < dur) begin
      n <= n + 16'h0001;
    end
  end
  assign carrier_activity = n < dur;
  assign bit_tick = carrier_activity && n < len;
  // Only frame bytes are strobed, never preamble or dribble
  assign byte_valid = carrier_activity && n < tally;
  assign {crc_fail_flag, odd_bit_flag, collide_flag} = carrier_activity ? flags : 3'h0;
endmodule : rx_port_model
`default_nettype wire
